// ===== pkg/indirect_data_address_unit_regs.svh
/*
 * Constants of the indirect data address unit: widths, the placement of
 * the pointer bytes and access ports in the core's 12-bit data space, and
 * the byte offsets of the software registers on the Avalon-MM slave.
 * Assumes it is included by its bare name before the package and module.
 */
`ifndef INDIRECT_DATA_ADDRESS_UNIT_REGS_SVH
`define INDIRECT_DATA_ADDRESS_UNIT_REGS_SVH

// Data space geometry
`define ADDR_W 12
`define DATA_W 8
`define NUM_PTRS 3

// Block of pointer registers and ports: address bits 11:5 equal this tag
`define REGION_TAG 7'h7f
// Address bits 4:3 pick the pointer, value 3 is not a pointer
`define NO_PTR_IDX 2'h3
// Address bits 2:0 pick the slot inside one pointer's group of eight
`define SLOT_LOW 3'h0
`define SLOT_HIGH 3'h1
`define SLOT_INDEXED 3'h3
`define SLOT_PREINC 3'h4
`define SLOT_POSTDEC 3'h5
`define SLOT_POSTINC 3'h6
`define SLOT_PLAIN 3'h7

// Avalon-MM byte offsets, pointer n sits at word n
`define OFS_STATUS 5'h0c
// Status register fields
`define STAT_ADDR_LSB 0
`define STAT_BUSY_BIT 12
`define STAT_HIT_BIT 13

`endif

// ===== pkg/indirect_data_address_unit_pkg.sv
/*
 * Types of the indirect data address unit: address classes, access modes,
 * phases and the packed state record of the top module.
 * Assumes the constants header sits beside this file on the include path.
 */
`include "indirect_data_address_unit_regs.svh"

package indirect_data_address_unit_pkg;

    typedef enum logic [1:0] {KIND_RAM, KIND_PTR_LOW, KIND_PTR_HIGH, KIND_PORT} addr_kind_t;

    typedef enum logic [2:0] {
        MODE_PLAIN,
        MODE_POSTDEC,
        MODE_POSTINC,
        MODE_PREINC,
        MODE_INDEXED
    } access_mode_t;

    typedef enum logic {PH_IDLE, PH_ACCESS} phase_t;

    typedef struct packed {
        addr_kind_t kind;
        access_mode_t mode;
        logic [1:0] idx;
    } addr_class_t;

    typedef struct packed {
        logic [`NUM_PTRS-1:0][`ADDR_W-1:0] ptr;
        phase_t phase;
        logic fromRam;
        logic [`ADDR_W-1:0] ramAddr;
        logic ramRead;
        logic ramWrite;
        logic [`DATA_W-1:0] ramWriteData;
        logic [`DATA_W-1:0] coreReadData;
        logic coreDone;
        logic zeroForced;
        logic statusHold;
        logic [`ADDR_W-1:0] lastAddr;
        logic virtualHit;
        logic busAck;
        logic [31:0] busReadData;
    } state_t;

endpackage : indirect_data_address_unit_pkg

// ===== src/indirect_data_address_unit.sv
/*
 * Indirect data address unit. Holds three 12-bit data pointers, resolves
 * every core access to an access port through them, drives the data RAM and lets
 * software see and load the pointers over an Avalon-MM slave.
 * Assumes an asynchronous data RAM read port whose data follows ramAddr
 * within the cycle, a core that raises coreReq only while coreReady is
 * high, and inputs synchronous to ref_clk.
 */
`timescale 1ns/1ps

module indirect_data_address_unit
    import indirect_data_address_unit_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [4:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Core data access port
    input wire logic coreReq,
    input wire logic coreWrite,
    input wire logic [`ADDR_W-1:0] coreAddr,
    input wire logic [`DATA_W-1:0] coreWriteData,
    input wire logic [`DATA_W-1:0] workingAccumulator,
    output logic coreReady,
    output logic coreDone,
    output logic [`DATA_W-1:0] coreReadData,
    output logic coreZeroForced,
    output logic coreStatusHold,
    // Data RAM
    output logic [`ADDR_W-1:0] ramAddr,
    output logic ramRead,
    output logic ramWrite,
    output logic [`DATA_W-1:0] ramWriteData,
    input wire logic [`DATA_W-1:0] ramReadData
);

    state_t s;
    state_t next_s;

    // Sorts a data address into RAM, pointer byte or access port
    function automatic addr_class_t classify(input logic [`ADDR_W-1:0] a);
        addr_class_t c;
        c.kind = KIND_RAM;
        c.mode = MODE_PLAIN;
        c.idx = a[4:3];
        if (a[11:5] == `REGION_TAG && a[4:3] != `NO_PTR_IDX) begin
            case (a[2:0])
                `SLOT_LOW: begin
                    c.kind = KIND_PTR_LOW;
                end
                `SLOT_HIGH: begin
                    c.kind = KIND_PTR_HIGH;
                end
                `SLOT_PLAIN: begin
                    c.kind = KIND_PORT;
                    c.mode = MODE_PLAIN;
                end
                `SLOT_POSTDEC: begin
                    c.kind = KIND_PORT;
                    c.mode = MODE_POSTDEC;
                end
                `SLOT_POSTINC: begin
                    c.kind = KIND_PORT;
                    c.mode = MODE_POSTINC;
                end
                `SLOT_PREINC: begin
                    c.kind = KIND_PORT;
                    c.mode = MODE_PREINC;
                end
                `SLOT_INDEXED: begin
                    c.kind = KIND_PORT;
                    c.mode = MODE_INDEXED;
                end
                default: begin
                    c.kind = KIND_RAM; // Spare slot falls through to RAM
                end
            endcase
        end
        return c;
    endfunction : classify

    // Handshake outputs straight from state, data outputs from flops
    assign coreReady = (s.phase == PH_IDLE);
    assign coreDone = s.coreDone;
    assign coreReadData = s.coreReadData;
    assign coreZeroForced = s.zeroForced;
    assign coreStatusHold = s.statusHold;
    assign ramAddr = s.ramAddr;
    assign ramRead = s.ramRead;
    assign ramWrite = s.ramWrite;
    assign ramWriteData = s.ramWriteData;
    assign avsReadData = s.busReadData;
    // One wait cycle on every bus access keeps read data registered
    assign avsWaitRequest = (avsRead || avsWrite) && !s.busAck;

    // Next-state logic for the core path and the bus slave
    always_comb begin
        addr_class_t req;
        addr_class_t tgt;
        logic [`ADDR_W-1:0] ptrNow;
        logic [`ADDR_W-1:0] ptrNew;
        logic [`ADDR_W-1:0] eff;
        logic [`ADDR_W-1:0] offset;
        logic indirect;
        logic [`DATA_W-1:0] byteNow;
        logic [31:0] busRead;
        req = classify(coreAddr);
        tgt = req;
        ptrNow = '0;
        ptrNew = '0;
        eff = coreAddr; // Direct access goes where the core points
        offset = {{(`ADDR_W - `DATA_W){workingAccumulator[`DATA_W-1]}}, workingAccumulator};
        indirect = (req.kind == KIND_PORT); // Ports hold no data
        byteNow = '0;
        busRead = '0;
        next_s = s;
        next_s.coreDone = 1'b0;

        // Own pointer of the addressed port
        if (req.kind != KIND_RAM) begin
            ptrNow = s.ptr[req.idx];
        end
        ptrNew = ptrNow;

        // Address and pointer update by port slot; 12-bit arithmetic
        if (indirect) begin
            case (req.mode)
                MODE_PLAIN: begin
                    eff = ptrNow;
                end
                MODE_POSTDEC: begin
                    eff = ptrNow;
                    ptrNew = ptrNow - 12'h001;
                end
                MODE_POSTINC: begin
                    eff = ptrNow;
                    ptrNew = ptrNow + 12'h001;
                end
                MODE_PREINC: begin
                    ptrNew = ptrNow + 12'h001;
                    eff = ptrNew;
                end
                MODE_INDEXED: begin
                    eff = ptrNow + offset; // Pointer and accumulator kept
                end
                default: begin
                    eff = ptrNow;
                end
            endcase
        end
        tgt = classify(eff);

        // Pointer byte seen at the final address, high nibble reads zero
        if (tgt.kind == KIND_PTR_LOW) begin
            byteNow = s.ptr[tgt.idx][7:0];
        end else if (tgt.kind == KIND_PTR_HIGH) begin
            byteNow = {4'h0, s.ptr[tgt.idx][11:8]};
        end

        case (s.phase)
            PH_IDLE: begin
                if (coreReq) begin
                    next_s.phase = PH_ACCESS;
                    next_s.fromRam = 1'b0;
                    next_s.zeroForced = 1'b0;
                    next_s.statusHold = 1'b0;
                    next_s.virtualHit = 1'b0;
                    next_s.lastAddr = eff;
                    // Stepping raises no flag, only the pointer moves
                    if (indirect) begin
                        next_s.ptr[req.idx] = ptrNew;
                    end
                    if (indirect && tgt.kind == KIND_PORT) begin
                        // A port seen through a pointer is no storage
                        next_s.virtualHit = 1'b1;
                        if (coreWrite) begin
                            next_s.statusHold = 1'b1;
                        end else begin
                            next_s.coreReadData = '0;
                            next_s.zeroForced = 1'b1;
                        end
                    end else if (tgt.kind == KIND_PTR_LOW || tgt.kind == KIND_PTR_HIGH) begin
                        if (coreWrite) begin
                            // Data wins over stepping of the same pointer
                            if (indirect && tgt.idx == req.idx) begin
                                next_s.ptr[tgt.idx] = ptrNow;
                            end
                            if (tgt.kind == KIND_PTR_LOW) begin
                                next_s.ptr[tgt.idx][7:0] = coreWriteData;
                            end else begin
                                next_s.ptr[tgt.idx][11:8] = coreWriteData[3:0];
                            end
                        end else begin
                            next_s.coreReadData = byteNow;
                        end
                    end else begin
                        // Ordinary data location, through the RAM
                        next_s.fromRam = 1'b1;
                        next_s.ramAddr = eff;
                        next_s.ramRead = !coreWrite;
                        next_s.ramWrite = coreWrite;
                        next_s.ramWriteData = coreWriteData;
                    end
                end
            end
            PH_ACCESS: begin
                // RAM strobes last one cycle; read data caught at its end
                next_s.ramRead = 1'b0;
                next_s.ramWrite = 1'b0;
                if (s.fromRam && s.ramRead) begin
                    next_s.coreReadData = ramReadData;
                end
                next_s.coreDone = 1'b1;
                next_s.phase = PH_IDLE;
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase

        // Bus read mux; unmapped words read as zero
        if (avsAddress[4:2] < 3'(`NUM_PTRS)) begin
            busRead[`ADDR_W-1:0] = s.ptr[avsAddress[3:2]];
        end else if (avsAddress == `OFS_STATUS) begin
            busRead[`STAT_ADDR_LSB +: `ADDR_W] = s.lastAddr;
            busRead[`STAT_BUSY_BIT] = (s.phase != PH_IDLE);
            busRead[`STAT_HIT_BIT] = s.virtualHit;
        end

        // Bus slave: data sampled in the wait cycle, write lands at ack
        next_s.busAck = (avsRead || avsWrite) && !s.busAck;
        if ((avsRead || avsWrite) && !s.busAck) begin
            next_s.busReadData = busRead;
        end
        // Software load comes last so it wins over the core path
        for (int i = 0; i < `NUM_PTRS; i++) begin
            if (avsWrite && s.busAck && avsAddress[4:2] == 3'(i)) begin
                if (avsByteEnable[0]) begin
                    next_s.ptr[i][7:0] = avsWriteData[7:0];
                end
                if (avsByteEnable[1]) begin
                    next_s.ptr[i][11:8] = avsWriteData[11:8];
                end
            end
        end
    end

    // State register; everything clears with reset
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

endmodule : indirect_data_address_unit

// ===== test/data_ram_model.sv
/*
 * Data RAM beside the unit: 4096 bytes, written at the clock edge, read
 * combinationally while ramRead is high.
 * Assumes the unit's single clock and RAM strobes as its outputs give them.
 */
`timescale 1ns/1ps
module data_ram_model (
    input wire logic ref_clk,
    input wire logic [11:0] ramAddr,
    input wire logic ramRead,
    input wire logic ramWrite,
    input wire logic [7:0] ramWriteData,
    output logic [7:0] ramReadData
);
    logic [7:0] mem [4096];
    logic [7:0] junk;
    // Cleared so that first reads are defined
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        junk = 8'h5a;
    end
    // Write port; pattern moves each cycle so stale data never looks valid
    always @(posedge ref_clk) begin
        junk <= ~junk + 8'h01;
        if (ramWrite) mem[ramAddr] <= ramWriteData;
    end
    assign ramReadData = ramRead ? mem[ramAddr] : junk;
endmodule : data_ram_model

// ===== test/indirect_data_address_unit_sva.sv
/*
 * Checker of the indirect data address unit, bound to its top module.
 * Assumes the constants header on the include path.
 */
`timescale 1ns/1ps
`include "indirect_data_address_unit_regs.svh"
module indirect_data_address_unit_sva (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic avsWaitRequest,
    input wire logic coreReq,
    input wire logic coreWrite,
    input wire logic [`ADDR_W-1:0] coreAddr,
    input wire logic [`DATA_W-1:0] coreWriteData,
    input wire logic coreReady,
    input wire logic coreDone,
    input wire logic [`DATA_W-1:0] coreReadData,
    input wire logic coreZeroForced,
    input wire logic coreStatusHold,
    input wire logic [`ADDR_W-1:0] ramAddr,
    input wire logic ramRead,
    input wire logic ramWrite,
    input wire logic [`DATA_W-1:0] ramWriteData,
    input wire logic [`DATA_W-1:0] ramReadData
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // Plain RAM below the pointer block, and a pointer byte hit directly
    wire logic directReq = coreReq && coreReady && coreAddr < 12'hfe0;
    // Group 3 of the block is plain RAM, so its first two slots are not bytes
    wire logic byteReq = coreReq && coreReady && coreAddr[11:5] == 7'h7f
        && coreAddr[4:3] != 2'h3 && coreAddr[2:1] == 2'h0;
    // Core access timing and RAM strobes
    property p_direct;
        directReq |=> (ramRead ^ ramWrite) && ramAddr == $past(coreAddr);
    endproperty
    a_direct: assert property (p_direct) else $error("direct address lost");
    property p_wdata;
        directReq && coreWrite |=> ramWrite && ramWriteData == $past(coreWriteData);
    endproperty
    a_wdata: assert property (p_wdata) else $error("write data lost");
    property p_rdata;
        ramRead |=> coreDone && coreReadData == $past(ramReadData);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data lost");
    property p_latency;
        coreReq && coreReady |=> !coreReady ##1 (coreDone && coreReady);
    endproperty
    a_latency: assert property (p_latency) else $error("done not in two cycles");
    property p_byte;
        byteReq |=> !ramRead && !ramWrite;
    endproperty
    a_byte: assert property (p_byte) else $error("pointer byte went to RAM");
    // A port reached through a pointer never touches RAM
    property p_hit_no_ram;
        coreDone && (coreZeroForced || coreStatusHold) |-> !$past(ramRead) && !$past(ramWrite);
    endproperty
    a_hit_no_ram: assert property (p_hit_no_ram) else $error("port hit used RAM");
    property p_zero;
        coreDone && coreZeroForced |-> coreReadData == 8'h00 && !coreStatusHold;
    endproperty
    a_zero: assert property (p_zero) else $error("forced read not zero");
    property p_wait;
        (avsRead || avsWrite) && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus wait too long");
endmodule : indirect_data_address_unit_sva

bind indirect_data_address_unit indirect_data_address_unit_sva i_sva (.ref_clk, .rst_b,
    .avsRead, .avsWrite, .avsWaitRequest, .coreReq, .coreWrite, .coreAddr, .coreWriteData,
    .coreReady, .coreDone, .coreReadData, .coreZeroForced, .coreStatusHold, .ramAddr,
    .ramRead, .ramWrite, .ramWriteData, .ramReadData);

// ===== test/indirect_data_address_unit_tb.sv
/*
 * Self-checking bench of the indirect data address unit with a RAM model.
 * Assumes the package, header and design compiled before it.
 */
`timescale 1ns/1ps
`include "indirect_data_address_unit_regs.svh"
`define CHK(a, b) begin samplesChecked++; if ((a) !== (b)) begin fails++; \
    $display("mismatch at %0t: got %h want %h", $time, a, b); end end
module indirect_data_address_unit_tb
    import indirect_data_address_unit_pkg::*;
;
    logic ref_clk = 0, rst_b = 0, avsRead = 0, avsWrite = 0, coreReq = 0, coreWrite = 0;
    logic [4:0] avsAddress = 0;
    logic [3:0] avsByteEnable = 4'h3;
    logic [31:0] avsWriteData = 0, avsReadData, q;
    logic [11:0] coreAddr = 0, ramAddr, ptr [3];
    logic [7:0] coreWriteData = 0, workingAccumulator = 0, coreReadData, ramWriteData, ramReadData;
    logic avsWaitRequest, coreReady, coreDone, coreZeroForced, coreStatusHold, ramRead, ramWrite;
    logic [7:0] mem [4096];
    int fails = 0, samplesChecked = 0, seed = 32'h9b40;
    indirect_data_address_unit i_dut (.ref_clk, .rst_b, .avsAddress, .avsRead, .avsWrite,
        .avsWriteData, .avsByteEnable, .avsReadData, .avsWaitRequest, .coreReq,
        .coreWrite, .coreAddr, .coreWriteData, .workingAccumulator, .coreReady, .coreDone,
        .coreReadData, .coreZeroForced, .coreStatusHold, .ramAddr, .ramRead, .ramWrite,
        .ramWriteData, .ramReadData);
    data_ram_model i_ram (.ref_clk, .ramAddr, .ramRead, .ramWrite, .ramWriteData, .ramReadData);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    // Bus cycle: hold until the rising edge that sees waitrequest low,
    // take read data and release at that same edge
    task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= wr;
        avsRead <= !wr;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (avsWaitRequest === 1'b0) break;
        end
        if (i == 20) begin
            fails++;
            print_verdict();
        end
        q = avsReadData;
        avsRead <= 0;
        avsWrite <= 0;
    endtask : av
    task automatic setp(input int n, input logic [11:0] v);
        av(1, 5'(n * 4), {20'h0, v});
        ptr[n] = v;
    endtask : setp
    // One core access, mirrored in the bench model and then compared
    task automatic core(input logic wr, input logic [11:0] a, input logic [7:0] d, w);
        int i, n, s, m;
        logic [11:0] p, e;
        logic [7:0] r;
        logic zf, sh, thru;
        @(posedge ref_clk);
        coreReq <= 1;
        coreWrite <= wr;
        coreAddr <= a;
        coreWriteData <= d;
        workingAccumulator <= w;
        @(posedge ref_clk);
        coreReq <= 0;
        for (i = 0; i < 20 && coreDone !== 1'b1; i++) @(negedge ref_clk);
        if (i == 20) begin
            fails++;
            print_verdict();
        end
        n = a[4:3];
        s = a[2:0];
        e = a;
        zf = 0;
        sh = 0;
        r = 0;
        thru = a[11:5] == 7'h7f && n < 3 && s > 2;
        if (thru) begin
            p = ptr[n];
            e = (s == 4) ? p + 12'h1 : (s == 3) ? p + {{4{w[7]}}, w} : p;
            ptr[n] = (s == 4 || s == 6) ? p + 12'h1 : (s == 5) ? p - 12'h1 : p;
        end
        m = e[4:3];
        if (e[11:5] == 7'h7f && m < 3 && e[2:0] != 2) begin
            if (e[2:0] > 1) begin
                zf = !wr;
                sh = wr;
            end else if (!wr) begin
                r = e[0] ? {4'h0, ((thru && m == n) ? p : ptr[m]) >> 8} : ((thru && m == n) ? p[7:0] : ptr[m][7:0]);
            end else begin
                if (thru && m == n) ptr[m] = p;
                if (e[0]) ptr[m][11:8] = d[3:0];
                else ptr[m][7:0] = d;
            end
        end else if (wr) mem[e] = d;
        else r = mem[e];
        if (!wr) `CHK(coreReadData, r)
        `CHK(coreZeroForced, zf)
        `CHK(coreStatusHold, sh)
        av(0, 5'h0c, 0);
        `CHK(q[13:0], {thru && (zf || sh), 1'b0, e})
        for (m = 0; m < 3; m++) begin
            av(0, 5'(m * 4), 0);
            `CHK(q, {20'h0, ptr[m]})
        end
    endtask : core
    initial begin
        foreach (mem[k]) mem[k] = 8'h00;
        foreach (ptr[k]) ptr[k] = 12'h000;
        repeat (3) @(posedge ref_clk);
        rst_b <= 1;
        av(0, 5'h10, 0);
        `CHK(q, 32'h0)
        // Every mode of every pointer, both directions, random values
        for (int n = 0; n < 3; n++) for (int s = 3; s < 8; s++) for (int wr = 1; wr >= 0; wr--) begin
            setp(n, 12'({$random(seed)} % 3840));
            core(wr[0], 12'hfe0 + 12'(8 * n + s), 8'($random(seed)), 8'($random(seed)));
            core(!wr[0], 12'({$random(seed)} % 4064), 8'($random(seed)), 8'h00);
        end
        // Carry, borrow and wrap to zero
        setp(0, 12'h0ff);
        core(1, 12'hfe6, 8'h3c, 8'h00);
        setp(1, 12'h000);
        core(0, 12'hfed, 8'h00, 8'h00);
        setp(2, 12'hfff);
        core(0, 12'hff6, 8'h00, 8'h00);
        // Pointer aimed at a port, and at pointer bytes
        setp(1, 12'hfe7);
        core(0, 12'hfef, 8'h00, 8'h00);
        core(1, 12'hfee, 8'h77, 8'h00);
        setp(0, 12'hfe0);
        core(1, 12'hfe6, 8'h55, 8'h00);
        setp(2, 12'hfe9);
        core(1, 12'hff6, 8'h0a, 8'h00);
        core(1, 12'hfe8, 8'ha5, 8'h00);
        core(0, 12'hfe9, 8'h00, 8'h00);
        // Lane 0 only: the high nibble of the pointer must survive
        avsByteEnable <= 4'h1;
        av(1, 5'h00, 32'h0000_0abc);
        ptr[0][7:0] = 8'hbc;
        avsByteEnable <= 4'h3;
        av(0, 5'h00, 0);
        `CHK(q, {20'h0, ptr[0]})
        print_verdict();
    end
endmodule : indirect_data_address_unit_tb
